/* include/efc_defs.svh */
// constants of the ecg frame composer: offsets, field positions, resets and timing
`ifndef EFC_DEFS_SVH
`define EFC_DEFS_SVH

// ==========================================================================
// register map
`define EFC_ADDR_W            8
`define EFC_DATA_W            24
`define EFC_ADDR_FRAME_COMPOSITION_CONTROL       8'h0A
`define EFC_ADDR_STATUS       8'h10
`define EFC_FRAME_COMPOSITION_CONTROL_RESET      24'h079000

// ==========================================================================
// frame control fields
`define EFC_BIT_ECG_HI        23
`define EFC_BIT_PACE          14
`define EFC_BIT_RESPM         13
`define EFC_BIT_RESPPH        12
`define EFC_BIT_LOFF          11
`define EFC_BIT_GPIO          10
`define EFC_BIT_CHECK         9
`define EFC_BIT_AUTO          7
`define EFC_BIT_RPT           6
`define EFC_BIT_FMT           4
`define EFC_SKIP_HI           3
`define EFC_SKIP_LO           2
`define EFC_RATE_HI           1
`define EFC_RATE_LO           0

// ==========================================================================
// status fields
`define EFC_STAT_DROP_HI      23
`define EFC_STAT_DROP_LO      16
`define EFC_STAT_CNT_HI       15
`define EFC_STAT_CNT_LO       1
`define EFC_STAT_BUSY         0

// ==========================================================================
// frame words, in send order
`define EFC_WORD_W            32
`define EFC_NUM_WORDS         12
`define EFC_NUM_ECG           5
`define EFC_WI_HDR            0
`define EFC_WI_ECG0           1
`define EFC_WI_PACE           6
`define EFC_WI_RESPM          7
`define EFC_WI_RESPPH         8
`define EFC_WI_LOFF           9
`define EFC_WI_GPIO           10
`define EFC_WI_CHECK          11

// header word fields
`define EFC_HDR_MARK          31
`define EFC_HDR_READY         30
`define EFC_HDR_PACE          29
`define EFC_HDR_RESP          28
`define EFC_HDR_LOFF          27
`define EFC_HDR_FMT           26
`define EFC_HDR_RATE_HI       25
`define EFC_HDR_RATE_LO       24

// check word
`define EFC_CRC_POLY          16'h1021
`define EFC_CRC_INIT          16'hFFFF

// ==========================================================================
// timing: frame rates and the cycle counts derived from the system clock
`define EFC_SYS_CLK_HZ        64'd250000000
`define EFC_RATE_2K_HZ        64'd2000
`define EFC_RATE_16K_HZ       64'd16000
`define EFC_RATE_128K_HZ      64'd128000
`define EFC_RATE_SLOW_MHZ     64'd31250
`define EFC_DIV_2K            (`EFC_SYS_CLK_HZ / `EFC_RATE_2K_HZ)
`define EFC_DIV_16K           (`EFC_SYS_CLK_HZ / `EFC_RATE_16K_HZ)
`define EFC_DIV_128K          (`EFC_SYS_CLK_HZ / `EFC_RATE_128K_HZ)
`define EFC_DIV_SLOW          ((`EFC_SYS_CLK_HZ * 64'd1000) / `EFC_RATE_SLOW_MHZ)
`define EFC_DIV_W             23

`endif

/* include/efc_pkg.sv */
// types shared by the ecg frame composer modules
`include "efc_defs.svh"

package efc_pkg;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    EFC_RATE_2K   = 2'b00,
    EFC_RATE_16K  = 2'b01,
    EFC_RATE_128K = 2'b10,
    EFC_RATE_SLOW = 2'b11
  } efc_rate_t;

  typedef enum logic [1:0] {
    EFC_ST_IDLE = 2'b00,
    EFC_ST_SEND = 2'b01,
    EFC_ST_WAIT = 2'b10
  } efc_state_t;

  // ==========================================================================
  // data types
  typedef logic [`EFC_WORD_W-1:0]                         efc_word_t;
  typedef logic [`EFC_NUM_ECG-1:0][`EFC_WORD_W-1:0]       efc_ecg_t;
  typedef logic [`EFC_NUM_WORDS-1:0][`EFC_WORD_W-1:0]     efc_snap_t;

  typedef struct packed {
    logic [`EFC_DATA_W-1:0]    ctrl;
    logic [`EFC_DIV_W-1:0]     div_cnt;
    logic [1:0]                skip_cnt;
    efc_state_t                st;
    logic [`EFC_NUM_WORDS-1:0] incl;
    efc_snap_t                 snap;
    logic [15:0]               crc;
    efc_word_t                 xfer_word;
    logic                      xfer_last;
    logic                      req_tgl;
    logic [2:0]                ack_sync;
    logic                      ack_seen;
    logic [14:0]               frame_cnt;
    logic [7:0]                drop_cnt;
    logic                      busy;
    logic [`EFC_DATA_W-1:0]    rd_data;
  } efc_core_t;

  typedef struct packed {
    logic [2:0]  rst_pipe;
    logic [2:0]  req_sync;
    logic        req_seen;
    efc_word_t   shreg;
    logic [4:0]  bit_cnt;
    logic        last;
    logic        ack_tgl;
    logic        dout;
    logic        valid;
    logic        frame;
  } efc_link_t;

endpackage

/* core/efc_link_shifter.sv */
// link-clock side of the ecg frame composer: shifts handed-over words out serially
`timescale 1ns/10ps
`include "efc_defs.svh"

module efc_link_shifter (
  input  wire logic              link_clk_i,
  input  wire logic              sys_rst_i,
  input  wire efc_pkg::efc_word_t word_i,
  input  wire logic              last_i,
  input  wire logic              req_tgl_i,
  output logic                   ack_tgl_o,
  output logic                   dout_o,
  output logic                   valid_o,
  output logic                   frame_o
);
  import efc_pkg::*;

  efc_link_t q;
  efc_link_t n;
  logic      lrst;
  logic      req_new;

  // ==========================================================================
  // reset and request synchronisers
  // reset asserts once it reaches the second stage, releases only when both late stages agree low
  assign lrst    = q.rst_pipe[2] | q.rst_pipe[1];
  // a request counts once the second and third stages agree
  assign req_new = (q.req_sync[2] == q.req_sync[1]) && (q.req_sync[2] != q.req_seen);

  // ==========================================================================
  // shifter
  always_comb begin
    n          = q;
    n.rst_pipe = {q.rst_pipe[1:0], sys_rst_i};
    n.req_sync = {q.req_sync[1:0], req_tgl_i};
    if (lrst) begin
      n.req_seen = 1'b0;
      n.shreg    = '0;
      n.bit_cnt  = 5'h00;
      n.last     = 1'b0;
      n.ack_tgl  = 1'b0;
      n.dout     = 1'b0;
      n.valid    = 1'b0;
      n.frame    = 1'b0;
    end else if (q.valid) begin
      if (q.bit_cnt != 5'h00) begin
        n.dout    = q.shreg[`EFC_WORD_W-1];
        n.shreg   = {q.shreg[`EFC_WORD_W-2:0], 1'b0};
        n.bit_cnt = q.bit_cnt - 5'h01;
      end else begin
        // word done: hand the slot back, close the frame on its last word
        n.valid   = 1'b0;
        n.dout    = 1'b0;
        n.ack_tgl = ~q.ack_tgl;
        n.frame   = ~q.last;
      end
    end else if (req_new) begin
      // word is stable in the system domain until the ack toggles back
      n.req_seen = q.req_sync[2];
      n.dout     = word_i[`EFC_WORD_W-1];
      n.shreg    = {word_i[`EFC_WORD_W-2:0], 1'b0};
      n.bit_cnt  = 5'h1F;
      n.last     = last_i;
      n.valid    = 1'b1;
      n.frame    = 1'b1;
    end
  end

  always_ff @(posedge link_clk_i) begin
    q <= n;
  end

  assign ack_tgl_o = q.ack_tgl;
  assign dout_o    = q.dout;
  assign valid_o   = q.valid;
  assign frame_o   = q.frame;

endmodule // efc_link_shifter

/* core/efc_frame_composer.sv */
// ecg frame composer: frame control register, frame timing and word selection
//
// Functional notes
// - five ecg word disable bits, 23 to 19
// - ecg word undefined once electrode is detached
// - pace, magnitude, detach, pins, check disables
// - breath phase word off after reset
// - auto drop omits flagged-clear optional words
// - fixed length unless auto drop or header-only repeat set
// - header-only repeat while data not ready
// - format bit: lead or electrode words; lead words only at 2k and 16k rates
// - skip field decimates frames by 1/2/4
// - rate field selects frame rate
`timescale 1ns/10ps
`include "efc_defs.svh"

module efc_frame_composer #(
  parameter int unsigned DIV_2K   = 32'(`EFC_DIV_2K),
  parameter int unsigned DIV_16K  = 32'(`EFC_DIV_16K),
  parameter int unsigned DIV_SLOW = 32'(`EFC_DIV_SLOW)
) (
  input  wire logic                    SYS_CLK_I,
  input  wire logic                    SYS_RST_I,
  input  wire logic [`EFC_ADDR_W-1:0]  REG_ADDR_I,
  input  wire logic [`EFC_DATA_W-1:0]  REG_WDATA_I,
  input  wire logic                    REG_WR_I,
  input  wire logic                    REG_RD_I,
  output logic      [`EFC_DATA_W-1:0]  REG_RDATA_O,
  input  wire logic                    DATA_READY_I,
  input  wire logic                    PACE_FLAG_I,
  input  wire logic                    BREATH_FLAG_I,
  input  wire logic                    DETACH_FLAG_I,
  input  wire efc_pkg::efc_ecg_t       ECG_ELECTRODE_I,
  input  wire efc_pkg::efc_ecg_t       ECG_LEAD_I,
  input  wire efc_pkg::efc_word_t      PACING_WORD_I,
  input  wire efc_pkg::efc_word_t      BREATH_MAG_WORD_I,
  input  wire efc_pkg::efc_word_t      BREATH_PHASE_WORD_I,
  input  wire efc_pkg::efc_word_t      DETACH_WORD_I,
  input  wire efc_pkg::efc_word_t      PORT_PINS_WORD_I,
  output logic                         BUSY_O,
  input  wire logic                    LINK_CLK_I,
  output logic                         LINK_DOUT_O,
  output logic                         LINK_VALID_O,
  output logic                         LINK_FRAME_O
);
  import efc_pkg::*;

  efc_core_t                   q;
  efc_core_t                   n;

  // ==========================================================================
  // control field views
  logic [`EFC_NUM_ECG-1:0]     ecg_word_off;
  logic                        pacing_word_off;
  logic                        breath_magnitude_word_off;
  logic                        breath_phase_word_off;
  logic                        electrode_detach_word_off;
  logic                        port_pins_word_off;
  logic                        check_word_off;
  logic                        auto_word_drop;
  logic                        header_repeat_until_ready;
  logic                        output_word_format;
  logic [1:0]                  skip_sel;
  efc_rate_t                   frame_rate_select;

  assign ecg_word_off              = q.ctrl[`EFC_BIT_ECG_HI -: `EFC_NUM_ECG];
  assign pacing_word_off           = q.ctrl[`EFC_BIT_PACE];
  assign breath_magnitude_word_off = q.ctrl[`EFC_BIT_RESPM];
  assign breath_phase_word_off     = q.ctrl[`EFC_BIT_RESPPH];
  assign electrode_detach_word_off = q.ctrl[`EFC_BIT_LOFF];
  assign port_pins_word_off        = q.ctrl[`EFC_BIT_GPIO];
  assign check_word_off            = q.ctrl[`EFC_BIT_CHECK];
  assign auto_word_drop            = q.ctrl[`EFC_BIT_AUTO];
  assign header_repeat_until_ready = q.ctrl[`EFC_BIT_RPT];
  assign output_word_format        = q.ctrl[`EFC_BIT_FMT];
  assign skip_sel                  = q.ctrl[`EFC_SKIP_HI:`EFC_SKIP_LO];
  assign frame_rate_select         = efc_rate_t'(q.ctrl[`EFC_RATE_HI:`EFC_RATE_LO]);

  // ==========================================================================
  // frame period and decimation
  logic [`EFC_DIV_W-1:0]       period_last;
  logic                        rate_tick;
  logic                        emit;
  logic                        fmt_electrode;

  always_comb begin
    unique case (frame_rate_select)
      EFC_RATE_2K:   period_last = `EFC_DIV_W'(DIV_2K - 32'd1);
      EFC_RATE_16K:  period_last = `EFC_DIV_W'(DIV_16K - 32'd1);
      EFC_RATE_128K: period_last = `EFC_DIV_W'(`EFC_DIV_128K - 64'd1);
      EFC_RATE_SLOW: period_last = `EFC_DIV_W'(DIV_SLOW - 32'd1);
    endcase
  end

  assign rate_tick = (q.div_cnt >= period_last);

  always_comb begin
    if (skip_sel[1]) begin
      emit = rate_tick && (q.skip_cnt == 2'b00);
    end else if (skip_sel[0]) begin
      emit = rate_tick && !q.skip_cnt[0];
    end else begin
      emit = rate_tick;
    end
  end

  // lead words exist only at the two middle rates; elsewhere electrode words go out
  assign fmt_electrode = output_word_format ||
                         (frame_rate_select != EFC_RATE_2K && frame_rate_select != EFC_RATE_16K);

  // ==========================================================================
  // per-electrode word choice and inclusion
  efc_ecg_t                    ecg_pick;
  logic [`EFC_NUM_ECG-1:0]     ecg_incl;

  genvar gi;
  generate
    for (gi = 0; gi < `EFC_NUM_ECG; gi++) begin : g_ecg
      // detached electrodes still send their slot; content is left undefined
      assign ecg_pick[gi] = fmt_electrode ? ECG_ELECTRODE_I[gi] : ECG_LEAD_I[gi];
      assign ecg_incl[gi] = !ecg_word_off[`EFC_NUM_ECG-1-gi];
    end
  endgenerate

  // ==========================================================================
  // header and inclusion mask at frame start
  efc_word_t                   hdr_word;
  logic [`EFC_NUM_WORDS-1:0]   start_incl;

  always_comb begin
    hdr_word                                 = '0;
    hdr_word[`EFC_HDR_MARK]                  = 1'b1;
    hdr_word[`EFC_HDR_READY]                 = DATA_READY_I;
    hdr_word[`EFC_HDR_PACE]                  = PACE_FLAG_I;
    hdr_word[`EFC_HDR_RESP]                  = BREATH_FLAG_I;
    hdr_word[`EFC_HDR_LOFF]                  = DETACH_FLAG_I;
    hdr_word[`EFC_HDR_FMT]                   = fmt_electrode;
    hdr_word[`EFC_HDR_RATE_HI:`EFC_HDR_RATE_LO] = frame_rate_select;
  end

  always_comb begin
    start_incl                                       = '0;
    start_incl[`EFC_WI_HDR]                          = 1'b1;
    start_incl[`EFC_WI_ECG0 +: `EFC_NUM_ECG]         = ecg_incl;
    start_incl[`EFC_WI_PACE]   = !pacing_word_off && !(auto_word_drop && !PACE_FLAG_I);
    start_incl[`EFC_WI_RESPM]  = !breath_magnitude_word_off && !(auto_word_drop && !BREATH_FLAG_I);
    start_incl[`EFC_WI_RESPPH] = !breath_phase_word_off;
    start_incl[`EFC_WI_LOFF]   = !electrode_detach_word_off && !(auto_word_drop && !DETACH_FLAG_I);
    start_incl[`EFC_WI_GPIO]   = !port_pins_word_off;
    start_incl[`EFC_WI_CHECK]  = !check_word_off;
    if (header_repeat_until_ready && !DATA_READY_I) begin
      start_incl             = '0;
      start_incl[`EFC_WI_HDR] = 1'b1;
    end
  end

  // ==========================================================================
  // next word: lowest bit still set in the mask
  logic [3:0]                  pick;
  logic [`EFC_NUM_WORDS-1:0]   pick_onehot;
  logic                        pick_last;
  efc_word_t                   pick_word;

  always_comb begin
    pick        = 4'h0;
    pick_onehot = '0;
    for (int i = `EFC_NUM_WORDS - 1; i >= 0; i--) begin
      if (q.incl[i]) begin
        pick = 4'(i);
      end
    end
    pick_onehot[pick] = 1'b1;
    pick_last         = ((q.incl & ~pick_onehot) == '0);
    if (pick == 4'(`EFC_WI_CHECK)) begin
      pick_word = {16'h0000, q.crc};
    end else begin
      pick_word = q.snap[pick];
    end
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c, input efc_word_t w);
    logic [15:0] r;
    r = c;
    for (int b = `EFC_WORD_W - 1; b >= 0; b--) begin
      if (r[15] ^ w[b]) begin
        r = {r[14:0], 1'b0} ^ `EFC_CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // main sequencer
  logic                        ack_tgl;
  logic                        ack_new;

  // ack change counts once the second and third stages agree
  assign ack_new = (q.ack_sync[2] == q.ack_sync[1]) && (q.ack_sync[2] != q.ack_seen);

  always_comb begin
    n          = q;
    n.rd_data  = '0;
    n.ack_sync = {q.ack_sync[1:0], ack_tgl};

    if (REG_WR_I && REG_ADDR_I == `EFC_ADDR_FRAME_COMPOSITION_CONTROL) begin
      // reserved bits are stored as written; the host keeps ones in 18:15
      n.ctrl = REG_WDATA_I;
    end
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `EFC_ADDR_FRAME_COMPOSITION_CONTROL: n.rd_data = q.ctrl;
        `EFC_ADDR_STATUS: n.rd_data = {q.drop_cnt, q.frame_cnt, q.busy};
        default:          n.rd_data = '0;
      endcase
    end

    if (rate_tick) begin
      n.div_cnt  = '0;
      n.skip_cnt = q.skip_cnt + 2'b01;
    end else begin
      n.div_cnt  = q.div_cnt + `EFC_DIV_W'(1);
    end

    unique case (q.st)
      EFC_ST_IDLE: begin
        if (emit) begin
          // snapshot everything so later input changes cannot tear a frame
          n.snap                                  = '0;
          n.snap[`EFC_WI_HDR]                     = hdr_word;
          n.snap[`EFC_WI_ECG0 +: `EFC_NUM_ECG]    = ecg_pick;
          n.snap[`EFC_WI_PACE]                    = PACING_WORD_I;
          n.snap[`EFC_WI_RESPM]                   = BREATH_MAG_WORD_I;
          n.snap[`EFC_WI_RESPPH]                  = BREATH_PHASE_WORD_I;
          n.snap[`EFC_WI_LOFF]                    = DETACH_WORD_I;
          n.snap[`EFC_WI_GPIO]                    = PORT_PINS_WORD_I;
          n.incl                                  = start_incl;
          n.crc                                   = `EFC_CRC_INIT;
          n.st                                    = EFC_ST_SEND;
        end
      end
      EFC_ST_SEND: begin
        n.xfer_word = pick_word;
        n.xfer_last = pick_last;
        n.req_tgl   = ~q.req_tgl;
        n.incl      = q.incl & ~pick_onehot;
        if (pick != 4'(`EFC_WI_CHECK)) begin
          n.crc = crc_step(q.crc, pick_word);
        end
        n.st = EFC_ST_WAIT;
      end
      EFC_ST_WAIT: begin
        if (ack_new) begin
          n.ack_seen = q.ack_sync[2];
          if (q.xfer_last) begin
            n.st        = EFC_ST_IDLE;
            n.frame_cnt = q.frame_cnt + 15'h0001;
          end else begin
            n.st = EFC_ST_SEND;
          end
        end
      end
      default: n.st = EFC_ST_IDLE;
    endcase

    // a frame due while the previous one is still on the link is dropped
    if (emit && q.st != EFC_ST_IDLE) begin
      n.drop_cnt = q.drop_cnt + 8'h01;
    end
    n.busy = (n.st != EFC_ST_IDLE);

    if (SYS_RST_I) begin
      n          = '0;
      n.ctrl     = `EFC_FRAME_COMPOSITION_CONTROL_RESET;
      n.st       = EFC_ST_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    q <= n;
  end

  assign REG_RDATA_O = q.rd_data;
  assign BUSY_O      = q.busy;

  // ==========================================================================
  // link clock domain
  efc_link_shifter u_link (
    .link_clk_i (LINK_CLK_I),
    .sys_rst_i  (SYS_RST_I),
    .word_i     (q.xfer_word),
    .last_i     (q.xfer_last),
    .req_tgl_i  (q.req_tgl),
    .ack_tgl_o  (ack_tgl),
    .dout_o     (LINK_DOUT_O),
    .valid_o    (LINK_VALID_O),
    .frame_o    (LINK_FRAME_O)
  );

endmodule // efc_frame_composer

/* dv/efc_chk.sv */
// port checker of the ecg frame composer
`timescale 1ns/10ps
`include "efc_defs.svh"
module efc_chk (
  input wire logic        SYS_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [23:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [23:0] REG_RDATA_O,
  input wire logic        BUSY_O,
  input wire logic        LINK_CLK_I,
  input wire logic        LINK_DOUT_O,
  input wire logic        LINK_VALID_O,
  input wire logic        LINK_FRAME_O
);
  logic [23:0] sh_q;
  logic [5:0]  vcnt_q;
  // ==========================================================
  // shadow of the control register, bit counter of a word
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I)
      sh_q <= `EFC_FRAME_COMPOSITION_CONTROL_RESET;
    else if (REG_WR_I && REG_ADDR_I == `EFC_ADDR_FRAME_COMPOSITION_CONTROL)
      sh_q <= REG_WDATA_I;
  end
  always_ff @(posedge LINK_CLK_I) begin
    if (SYS_RST_I || !LINK_VALID_O)
      vcnt_q <= 6'h00;
    else
      vcnt_q <= vcnt_q + 6'h01;
  end
  // ==========================================================
  // assertions
  a_ctrl_readback: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $past(REG_RD_I) && $past(REG_ADDR_I) == `EFC_ADDR_FRAME_COMPOSITION_CONTROL |-> REG_RDATA_O == $past(sh_q))
    else $error("control read differs");
  a_rd_idle_zero: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !$past(REG_RD_I) |-> REG_RDATA_O == 24'h000000) else $error("read data not zero");
  a_unmapped_zero: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $past(REG_RD_I) && $past(REG_ADDR_I) != `EFC_ADDR_FRAME_COMPOSITION_CONTROL && $past(REG_ADDR_I) != `EFC_ADDR_STATUS
    |-> REG_RDATA_O == 24'h000000) else $error("unmapped read not zero");
  a_busy_start: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $rose(BUSY_O) |-> !LINK_FRAME_O) else $error("frame overlaps next");
  a_valid_framed: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
    LINK_VALID_O |-> LINK_FRAME_O && BUSY_O) else $error("valid outside frame");
  a_word_len: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
    $fell(LINK_VALID_O) |-> vcnt_q == 6'h20) else $error("word not 32 bits");
  a_header_mark: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
    $rose(LINK_FRAME_O) |-> LINK_VALID_O && LINK_DOUT_O) else $error("header mark missing");
  a_frame_end: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
    $fell(LINK_FRAME_O) |-> $fell(LINK_VALID_O)) else $error("frame end not at word end");
  c_frame: cover property (@(posedge LINK_CLK_I) $rose(LINK_FRAME_O));
  c_read: cover property (@(posedge SYS_CLK_I) REG_RD_I);
  c_hdr_only: cover property (@(posedge LINK_CLK_I) $rose(LINK_FRAME_O) ##32 $fell(LINK_FRAME_O));
endmodule // efc_chk

bind efc_frame_composer efc_chk u_chk (.SYS_CLK_I, .SYS_RST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
  .REG_RD_I, .REG_RDATA_O, .BUSY_O, .LINK_CLK_I, .LINK_DOUT_O, .LINK_VALID_O, .LINK_FRAME_O);

/* dv/efc_link_rx.sv */
// link-side host model: gathers serial words of each frame
`timescale 1ns/10ps
module efc_link_rx (
  input  wire logic         link_clk_i,
  input  wire logic         dout_i,
  input  wire logic         valid_i,
  input  wire logic         frame_i,
  output logic [15:0][31:0] words_o,
  output logic [4:0]        count_o,
  output logic [7:0]        frames_o
);
  logic [31:0] sh = 32'h00000000;
  logic [5:0]  nb = 6'h00;
  logic [4:0]  nw = 5'h00;
  logic        fr_q = 1'b0;
  initial begin
    words_o = '0;
    count_o = 5'h00;
    frames_o = 8'h00;
  end
  always @(posedge link_clk_i) begin
    if (frame_i && !fr_q)
      nw = 5'h00;
    if (valid_i) begin
      sh = {sh[30:0], dout_i};
      nb = nb + 6'h01;
      if (nb == 6'h20) begin
        words_o[nw[3:0]] = sh;
        nw = nw + 5'h01;
        nb = 6'h00;
      end
    end else
      nb = 6'h00;
    // length is taken per frame, it may vary
    if (!frame_i && fr_q) begin
      count_o = nw;
      frames_o = frames_o + 8'h01;
    end
    fr_q = frame_i;
  end
endmodule // efc_link_rx

/* dv/efc_frame_composer_tb_top.sv */
// testbench of the ecg frame composer
`timescale 1ns/10ps
`include "efc_defs.svh"
module efc_frame_composer_tb_top;
  import efc_pkg::*;
  logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic ready = 1'b1, pace_f = 1'b1, br_f = 1'b1, det_f = 1'b1, busy, dout, valid, frame;
  logic [7:0] addr = 8'h00, frames;
  logic [23:0] wdata = 24'h000000, rdata;
  logic [4:0] cnt;
  logic [15:0][31:0] words;
  efc_ecg_t ecg_e, ecg_l;
  efc_word_t pw = 32'h50000001, bmw = 32'h50000002, bpw = 32'h50000003;
  efc_word_t dw = 32'h50000004, ppw = 32'h50000005;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  always #3 link_clk = ~link_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  efc_frame_composer #(.DIV_2K(400), .DIV_16K(200), .DIV_SLOW(600)) uut (.SYS_CLK_I(sys_clk),
    .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
    .REG_RDATA_O(rdata), .DATA_READY_I(ready), .PACE_FLAG_I(pace_f), .BREATH_FLAG_I(br_f),
    .DETACH_FLAG_I(det_f), .ECG_ELECTRODE_I(ecg_e), .ECG_LEAD_I(ecg_l), .PACING_WORD_I(pw),
    .BREATH_MAG_WORD_I(bmw), .BREATH_PHASE_WORD_I(bpw), .DETACH_WORD_I(dw), .PORT_PINS_WORD_I(ppw),
    .BUSY_O(busy), .LINK_CLK_I(link_clk), .LINK_DOUT_O(dout), .LINK_VALID_O(valid), .LINK_FRAME_O(frame));
  efc_link_rx host (.link_clk_i(link_clk), .dout_i(dout), .valid_i(valid), .frame_i(frame),
    .words_o(words), .count_o(cnt), .frames_o(frames));
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 chk("read data", {8'h00, e}, {8'h00, rdata});
  endtask
  // waits for n frame ends; a control write lands on the frame after the one in flight
  task automatic wait_fr(input int n);
    logic [7:0] f;
    int k;
    repeat (n) begin
      f = frames;
      k = 0;
      while (frames === f && k < 20000) begin
        @(posedge sys_clk);
        k++;
      end
      if (frames === f) begin
        error_cnt++;
        $display("mismatch frame end expected %0h seen %0h", f + 8'h01, frames);
        tally_and_finish();
      end
    end
  endtask
  task automatic grab(input logic [23:0] c, input logic [4:0] n, input logic [7:0] h);
    wr(`EFC_ADDR_FRAME_COMPOSITION_CONTROL, c);
    wait_fr(2);
    chk("word count", {27'h0, n}, {27'h0, cnt});
    chk("header", {24'h0, h}, {24'h0, words[0][31:24]});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(`EFC_ADDR_FRAME_COMPOSITION_CONTROL, 24'h079000);
    wr(`EFC_ADDR_FRAME_COMPOSITION_CONTROL, 24'h5FA6D5);
    wr(8'h33, 24'h000000);
    rd(`EFC_ADDR_FRAME_COMPOSITION_CONTROL, 24'h5FA6D5);
    rd(8'h33, 24'h000000);
    $display("test regs done");
  endtask
  task automatic t_words();
    grab(24'h079000, 5'd11, 8'hF8);
    chk("lead 0", ecg_l[0], words[1]);
    chk("lead 4", ecg_l[4], words[5]);
    chk("pace", pw, words[6]);
    chk("pins", ppw, words[9]);
    grab(24'hF78610, 5'd6, 8'hFC);
    chk("electrode 4", ecg_e[4], words[1]);
    chk("phase", bpw, words[4]);
    $display("test words done");
  endtask
  task automatic t_auto();
    br_f <= 1'b0;
    det_f <= 1'b0;
    grab(24'h079080, 5'd9, 8'hE0);
    chk("pace kept", pw, words[6]);
    chk("pins after", ppw, words[7]);
    grab(24'h079000, 5'd11, 8'hE0);
    br_f <= 1'b1;
    det_f <= 1'b1;
    $display("test auto done");
  endtask
  task automatic t_repeat();
    ready <= 1'b0;
    grab(24'h079040, 5'd1, 8'hB8);
    grab(24'h079000, 5'd11, 8'hB8);
    ready <= 1'b1;
    $display("test repeat done");
  endtask
  task automatic t_timing();
    logic [7:0] cv [7] = '{8'h00, 8'h01, 8'h12, 8'h03, 8'h04, 8'h08, 8'h0C};
    int pv [7] = '{400, 200, 1953, 600, 800, 1600, 1600};
    int t;
    foreach (cv[i]) begin
      wr(`EFC_ADDR_FRAME_COMPOSITION_CONTROL, 24'hFFFE00 | {16'h0, cv[i]});
      wait_fr(2);
      t = cyc;
      wait_fr(1);
      chk("rate code", {30'h0, cv[i][1:0]}, {30'h0, words[0][25:24]});
      check_count++;
      if (cyc - t < pv[i] - 6 || cyc - t > pv[i] + 6) begin
        error_cnt++;
        $display("mismatch frame period expected %0d seen %0d", pv[i], cyc - t);
      end
    end
    $display("test timing done");
  endtask
  initial begin
    for (int i = 0; i < 5; i++) begin
      ecg_e[i] = 32'hE0000000 | 32'(i);
      ecg_l[i] = 32'hA0000000 | 32'(i);
    end
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_words();
    t_auto();
    t_repeat();
    t_timing();
    tally_and_finish();
  end
endmodule // efc_frame_composer_tb_top
